/* File: mbxc_gateway.sv */
/*
 * Request sequencer of the gateway exception checker, with event category
 * and device class encoders.
 * Assumes request fields and point status stand valid with req_valid.
 */
`timescale 1ns/10ps
module mbxc_gateway
    import mbxc_pkg::*;
(
    input  wire logic                  clock,            // 250 MHz clock
    input  wire logic                  rst_n,            // Asynchronous reset, active low
    input  wire logic                  req_valid,        // Request present
    input  wire logic [15:0]           req_trans_id,     // Transaction identifier
    input  wire logic [15:0]           req_proto_id,     // Protocol identifier
    input  wire logic [7:0]            req_unit_id,      // Unit ID
    input  wire logic [7:0]            req_func,         // Function code
    input  wire logic [15:0]           req_addr,         // Start register
    input  wire logic [15:0]           req_count,        // Register count
    input  wire logic                  unit_cfg,         // Unit ID set up for monitoring
    input  wire logic                  panel_online,     // Target panel reachable
    input  wire logic                  point_present,    // Addressed point exists
    input  wire logic                  point_analog,     // Addressed points are 4-20 mA
    input  wire logic                  wr_enable,        // Command writes allowed
    input  wire logic                  wr_data_ok,       // Write data valid for register
    input  wire logic [NUM_STATES-1:0] point_state,      // Active states of a point
    input  wire logic                  point_absent,     // Point not fitted
    input  wire logic [7:0]            device_type,      // Device type code
    output logic                       req_ready,        // Ready for a request
    output logic                       resp_valid,       // Response pulse
    output logic                       resp_exc,         // Response is an exception
    output logic [7:0]                 resp_func,        // Returned function code
    output logic [7:0]                 resp_code,        // Exception code
    output logic [15:0]                resp_trans_id,    // Echoed transaction identifier
    output logic [7:0]                 resp_unit_id,     // Echoed Unit ID
    output logic                       resp_zero_fill,   // Reply data is all zeros
    output logic                       analog_poll_start,// Start polling the analog group
    output logic [7:0]                 event_category,   // Encoded event category
    output logic [1:0]                 device_class      // Device type class
);
    typedef struct packed {
        mbxc_state_t st;
        logic        ready;
        logic [15:0] trans;
        logic [15:0] proto;
        logic [7:0]  unit;
        logic [7:0]  func;
        logic [15:0] addr;
        logic [15:0] count;
        logic [5:0]  flags;
        logic        resp_valid;
        logic        resp_exc;
        logic [7:0]  resp_func;
        logic [7:0]  resp_code;
        logic [15:0] resp_trans;
        logic [7:0]  resp_unit;
        logic        zero_fill;
        logic        poll_start;
        logic        last_valid;
        logic [15:0] last_addr;
        logic [15:0] last_count;
        logic [7:0]  category;
        logic [1:0]  dev_class;
    } mbxc_top_t;

    mbxc_top_t state_reg;
    mbxc_top_t state_next;
    mbxc_chk_if chk ();

    // Highest-priority active state wins; other states stay visible on point_state
    function automatic logic [7:0] cat_encode(input logic [NUM_STATES-1:0] st,
                                              input logic absent);
        logic [7:0] table_v [NUM_STATES];
        logic [7:0] cat;
        table_v = '{CAT_FIRE, CAT_LIFE_SEC, CAT_LIFE_PROC, CAT_MEDICAL,          // R15
                    CAT_PROP_SEC, CAT_PROP_PROC, CAT_GUARD_TOUR, CAT_EQUIP_SUPV, // R16
                    CAT_DIS_ALARM, CAT_DIS_ACTIVE, CAT_NONFIRE, CAT_NONFIRE_NOACK}; // R17
        cat = CAT_NONE;                                                      // R18
        for (int i = NUM_STATES - 1; i >= 0; i--) begin                      // R19
            if (st[i]) begin
                cat = table_v[i];
            end
        end
        return absent ? CAT_NOT_PRESENT : cat;                               // R18
    endfunction : cat_encode

    function automatic logic [1:0] type_class(input logic [7:0] t);
        if (t >= DET_TYPE_LO && t <= DET_TYPE_HI) begin                      // R20
            return CLASS_DETECTOR;
        end else if (t > DET_TYPE_HI && t <= MON_TYPE_HI) begin
            return CLASS_MONITOR;
        end else if (t > MON_TYPE_HI && t <= CTL_TYPE_HI) begin
            return CLASS_CONTROL;
        end
        return CLASS_NONE;
    endfunction : type_class

    // ====================================================================
    // Checker hookup
    assign chk.start         = (state_reg.st == MBXC_CHECK);
    assign chk.proto_id      = state_reg.proto;
    assign chk.unit_id       = state_reg.unit;
    assign chk.func_code     = state_reg.func;
    assign chk.start_addr    = state_reg.addr;
    assign chk.reg_count     = state_reg.count;
    assign chk.unit_cfg      = state_reg.flags[5];
    assign chk.panel_online  = state_reg.flags[4];
    assign chk.point_present = state_reg.flags[3];
    assign chk.point_analog  = state_reg.flags[2];
    assign chk.wr_enable     = state_reg.flags[1];
    assign chk.wr_data_ok    = state_reg.flags[0];

    mbxc_checker u_checker (
        .clock (clock),
        .rst_n (rst_n),
        .chk   (chk)
    );

    // ====================================================================
    // Sequencer
    always_comb begin
        logic same_group;
        state_next = state_reg;
        same_group = state_reg.last_valid && state_reg.last_addr == state_reg.addr &&
                     state_reg.last_count == state_reg.count;
        state_next.resp_valid = 1'b0;
        state_next.poll_start = 1'b0;
        state_next.category = cat_encode(point_state, point_absent);
        state_next.dev_class = type_class(device_type);
        case (state_reg.st)
            MBXC_IDLE: begin
                if (req_valid && state_reg.ready) begin                      // R21
                    state_next.st = MBXC_CHECK;
                    state_next.ready = 1'b0;
                    state_next.trans = req_trans_id;
                    state_next.proto = req_proto_id;
                    state_next.unit = req_unit_id;
                    state_next.func = req_func;
                    state_next.addr = req_addr;
                    state_next.count = req_count;
                    state_next.flags = {unit_cfg, panel_online, point_present,
                                        point_analog, wr_enable, wr_data_ok};
                end
            end
            MBXC_CHECK: begin
                state_next.st = MBXC_WAIT;
            end
            MBXC_WAIT: begin
                if (chk.done) begin
                    state_next.st = MBXC_RESP;
                    state_next.resp_valid = 1'b1;
                    state_next.resp_exc = (chk.exc_code != EXC_NONE);        // R1
                    state_next.resp_code = chk.exc_code;                     // R3
                    state_next.resp_func = (chk.exc_code != EXC_NONE) ?
                                           (state_reg.func | FC_EXC_FLAG) :
                                           state_reg.func;                   // R2
                    state_next.resp_trans = state_reg.trans;                 // R24
                    state_next.resp_unit = state_reg.unit;                   // R24
                    state_next.zero_fill = chk.analog_read && !same_group;   // R22
                    state_next.poll_start = chk.analog_read && !same_group;  // R22
                    if (chk.analog_read) begin
                        state_next.last_valid = 1'b1;
                        state_next.last_addr = state_reg.addr;
                        state_next.last_count = state_reg.count;
                    end
                end
            end
            MBXC_RESP: begin
                state_next.st = MBXC_IDLE;
                state_next.ready = 1'b1;
            end
            default: begin
                state_next.st = MBXC_IDLE;
                state_next.ready = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= '0;
            state_reg.ready <= 1'b1;
            state_reg.st <= MBXC_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    assign req_ready         = state_reg.ready;
    assign resp_valid        = state_reg.resp_valid;
    assign resp_exc          = state_reg.resp_exc;
    assign resp_func         = state_reg.resp_func;
    assign resp_code         = state_reg.resp_code;
    assign resp_trans_id     = state_reg.resp_trans;
    assign resp_unit_id      = state_reg.resp_unit;
    assign resp_zero_fill    = state_reg.zero_fill;
    assign analog_poll_start = state_reg.poll_start;
    assign event_category    = state_reg.category;
    assign device_class      = state_reg.dev_class;

    // ====================================================================
    // Assertions
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    logic accept;
    assign accept = req_valid && req_ready;

    a_resp_latency: assert property (accept |-> ##3 resp_valid)        // R1
        else $error("response not given three cycles after a request");
    a_exc_func_bit: assert property (resp_valid && resp_exc |->
        resp_func == ($past(req_func, 3) | FC_EXC_FLAG))               // R2
        else $error("exception function code lacks its top bit");
    a_code_in_data: assert property (resp_valid |->
        resp_exc == (resp_code != EXC_NONE))                           // R3
        else $error("exception flag and code disagree");
    a_proto_check: assert property (accept && req_proto_id != PROTO_ID_MODBUS |->
        ##3 resp_code == EXC_ILLEGAL_FUNC)                             // R4
        else $error("bad protocol identifier not refused");
    a_control_refused: assert property (accept && req_proto_id == PROTO_ID_MODBUS &&
        unit_cfg && req_func == FC_WRITE_SINGLE && !wr_enable |->
        ##3 resp_code == EXC_ILLEGAL_FUNC)                             // R6
        else $error("control command not refused");
    a_count_limit: assert property (accept && req_proto_id == PROTO_ID_MODBUS &&
        unit_cfg && req_func == FC_READ_HOLD && req_count > MAX_READ_REGS |->
        ##3 resp_code == EXC_ILLEGAL_VALUE)                            // R10
        else $error("oversize read not refused");
    a_unit_path: assert property (accept && req_proto_id == PROTO_ID_MODBUS &&
        !unit_cfg |-> ##3 resp_code == EXC_PATH_FAILED)                // R13
        else $error("unconfigured unit not refused");
    a_one_at_time: assert property (accept |=> !req_ready [*3])        // R21
        else $error("second request taken before the response");
    a_echo_ids: assert property (resp_valid |-> resp_trans_id == $past(req_trans_id, 3)
        && resp_unit_id == $past(req_unit_id, 3))                      // R24
        else $error("response does not echo request identifiers");
    a_absent_cat: assert property (point_absent |=>
        event_category == CAT_NOT_PRESENT)                             // R18
        else $error("absent point not encoded as not present");

    c_exception: cover property (resp_valid && resp_exc);
    c_normal: cover property (resp_valid && !resp_exc);
    c_analog_init: cover property (analog_poll_start);
    c_target_fail: cover property (resp_valid && resp_code == EXC_TARGET_FAILED);
endmodule : mbxc_gateway

/* File: mbxc_pkg.sv */
/*
 * Constants, codes and field layouts of the request exception checker.
 * Assumes one 250 MHz clock and an asynchronous active-low reset around it.
 */
// Overview of operation
// [R1] Invalid command or invalid register read gets an exception response, not a reply.
// [R2] Exception response returns the request function code with its top bit set.
// [R3] Exception response carries the applicable exception code in its data field.
// [R4] Protocol identifier must be zero; otherwise answer illegal function 0x01.
// [R5] Function supported by neither gateway nor panel gets illegal function 0x01.
// [R6] Any control command is refused with illegal function 0x01; the checker refuses writes only while wr_enable is low.
// [R7] Register range unsupported for the target panel gets illegal address 0x02.
// [R8] Valid range but absent detector, module or zone gets illegal address 0x02.
// [R9] Analog read from a non 4-20 mA point gets illegal address 0x02.
// [R10] Reads above 100 registers get illegal data value 0x03.
// [R11] Analog reads above 10 registers get illegal data value 0x03.
// [R12] Command write with data invalid for the register gets 0x03.
// [R13] Unit ID not configured for monitoring gets gateway path failed 0x0A.
// [R14] Target panel offline or network failed gets gateway target failed 0x0B.
// [R15] Life-safety categories: fire 10H, life security 11H, life process 12H, medical 13H.
// [R16] Property security 20H, property process 21H, guard tour 30H, equipment 40H.
// [R17] Disabled alarm 52H, disabled active 55H, non-fire 71H, non-fire no ack 72H.
// [R18] No active status writes zero; absent device writes 0xFF.
// [R19] A point may hold several states at once.
// [R20] Device types: detectors 1-50, monitors 51-150, control modules 151-250.
// [R21] Client waits for each response before sending the next request.
// [R22] First read of an analog group starts polling and returns zeros.
// [R23] Checks run protocol, unit, function, count, address; first failure reported.
// [R24] Exception response echoes transaction identifier and Unit ID.
package mbxc_pkg;
    // ====================================================================
    // Protocol and exception codes
    localparam logic [15:0] PROTO_ID_MODBUS   = 16'h0000;
    localparam logic [7:0]  EXC_NONE          = 8'h00;
    localparam logic [7:0]  EXC_ILLEGAL_FUNC  = 8'h01;
    localparam logic [7:0]  EXC_ILLEGAL_ADDR  = 8'h02;
    localparam logic [7:0]  EXC_ILLEGAL_VALUE = 8'h03;
    localparam logic [7:0]  EXC_PATH_FAILED   = 8'h0a;
    localparam logic [7:0]  EXC_TARGET_FAILED = 8'h0b;
    localparam logic [7:0]  FC_EXC_FLAG       = 8'h80;
    // ====================================================================
    // Function codes
    localparam logic [7:0]  FC_WRITE_COIL     = 8'h05;
    localparam logic [7:0]  FC_READ_HOLD      = 8'h03;
    localparam logic [7:0]  FC_READ_INPUT     = 8'h04;
    localparam logic [7:0]  FC_WRITE_SINGLE   = 8'h06;
    localparam logic [7:0]  FC_WRITE_COILS    = 8'h0f;
    localparam logic [7:0]  FC_WRITE_MULTI    = 8'h10;
    localparam logic [7:0]  FC_DEVICE_ID      = 8'h2b;
    // ====================================================================
    // Count limits and register space
    localparam logic [15:0] MAX_READ_REGS     = 16'h0064;
    localparam logic [15:0] MAX_ANALOG_REGS   = 16'h000a;
    localparam logic [16:0] ADDR_HI           = 17'h089ff;
    localparam logic [15:0] ANALOG_LO         = 16'h7530;
    localparam logic [15:0] ANALOG_HI         = 16'h7917;
    // ====================================================================
    // Event categories
    localparam logic [7:0]  CAT_NONE          = 8'h00;
    localparam logic [7:0]  CAT_FIRE          = 8'h10;
    localparam logic [7:0]  CAT_LIFE_SEC      = 8'h11;
    localparam logic [7:0]  CAT_LIFE_PROC     = 8'h12;
    localparam logic [7:0]  CAT_MEDICAL       = 8'h13;
    localparam logic [7:0]  CAT_PROP_SEC      = 8'h20;
    localparam logic [7:0]  CAT_PROP_PROC     = 8'h21;
    localparam logic [7:0]  CAT_GUARD_TOUR    = 8'h30;
    localparam logic [7:0]  CAT_EQUIP_SUPV    = 8'h40;
    localparam logic [7:0]  CAT_DIS_ALARM     = 8'h52;
    localparam logic [7:0]  CAT_DIS_ACTIVE    = 8'h55;
    localparam logic [7:0]  CAT_NONFIRE       = 8'h71;
    localparam logic [7:0]  CAT_NONFIRE_NOACK = 8'h72;
    localparam logic [7:0]  CAT_NOT_PRESENT   = 8'hff;
    localparam int          NUM_STATES        = 12;
    // ====================================================================
    // Device type classes
    localparam logic [7:0]  DET_TYPE_LO       = 8'h01;
    localparam logic [7:0]  DET_TYPE_HI       = 8'h32;
    localparam logic [7:0]  MON_TYPE_HI       = 8'h96;
    localparam logic [7:0]  CTL_TYPE_HI       = 8'hfa;
    localparam logic [1:0]  CLASS_NONE        = 2'h0;
    localparam logic [1:0]  CLASS_DETECTOR    = 2'h1;
    localparam logic [1:0]  CLASS_MONITOR     = 2'h2;
    localparam logic [1:0]  CLASS_CONTROL     = 2'h3;
    // ====================================================================
    // Timing
    localparam int          CLK_PERIOD_NS     = 4;
    localparam int          RESP_LATENCY      = 3;

    typedef enum logic [1:0] {
        MBXC_IDLE  = 2'b00,
        MBXC_CHECK = 2'b01,
        MBXC_WAIT  = 2'b10,
        MBXC_RESP  = 2'b11
    } mbxc_state_t;
endpackage : mbxc_pkg

/* File: mbxc_chk_if.sv */
/*
 * Carrier between the request sequencer and the request checker.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/10ps
interface mbxc_chk_if;
    logic        start;
    logic [15:0] proto_id;
    logic [7:0]  unit_id;
    logic [7:0]  func_code;
    logic [15:0] start_addr;
    logic [15:0] reg_count;
    logic        unit_cfg;
    logic        panel_online;
    logic        point_present;
    logic        point_analog;
    logic        wr_enable;
    logic        wr_data_ok;
    logic        done;
    logic [7:0]  exc_code;
    logic        analog_read;

    modport ctrl (output start, proto_id, unit_id, func_code, start_addr, reg_count,
                  unit_cfg, panel_online, point_present, point_analog, wr_enable,
                  wr_data_ok, input done, exc_code, analog_read);
    modport verdict (input start, proto_id, unit_id, func_code, start_addr, reg_count,
                     unit_cfg, panel_online, point_present, point_analog, wr_enable,
                     wr_data_ok, output done, exc_code, analog_read);
endinterface : mbxc_chk_if

/* File: mbxc_checker.sv */
/*
 * Request checker: one clock after start it reports the first failing check.
 * Assumes the request fields stand steady while start is high.
 */
`timescale 1ns/10ps
module mbxc_checker
    import mbxc_pkg::*;
(
    input  wire logic clock,  // 250 MHz clock
    input  wire logic rst_n,  // Asynchronous reset, active low
    mbxc_chk_if.verdict chk   // Request fields in, verdict out
);
    typedef struct packed {
        logic       done;
        logic [7:0] code;
        logic       analog;
    } mbxc_chk_t;

    mbxc_chk_t state_reg;
    mbxc_chk_t state_next;

    function automatic logic is_write(input logic [7:0] fc);
        return fc == FC_WRITE_COIL || fc == FC_WRITE_SINGLE ||
               fc == FC_WRITE_COILS || fc == FC_WRITE_MULTI;
    endfunction : is_write

    function automatic logic is_read(input logic [7:0] fc);
        return fc == FC_READ_HOLD || fc == FC_READ_INPUT;
    endfunction : is_read

    // ====================================================================
    // Ordered checks
    always_comb begin
        logic [16:0] last_addr;
        logic        analog;
        last_addr = 17'({1'b0, chk.start_addr} + {1'b0, chk.reg_count} - 17'h00001);
        analog = is_read(chk.func_code) && chk.start_addr >= ANALOG_LO &&
                 chk.start_addr <= ANALOG_HI;
        state_next.done = chk.start;
        state_next.analog = 1'b0;
        state_next.code = EXC_NONE;
        if (chk.proto_id != PROTO_ID_MODBUS) begin                          // R4 R23
            state_next.code = EXC_ILLEGAL_FUNC;
        end else if (!chk.unit_cfg) begin                                   // R13
            state_next.code = EXC_PATH_FAILED;
        end else if (is_write(chk.func_code) && !chk.wr_enable) begin       // R6
            state_next.code = EXC_ILLEGAL_FUNC;
        end else if (!is_write(chk.func_code) && !is_read(chk.func_code) &&
                     chk.func_code != FC_DEVICE_ID) begin                   // R5
            state_next.code = EXC_ILLEGAL_FUNC;
        end else if (is_read(chk.func_code) && (chk.reg_count == 16'h0000 ||
                     chk.reg_count > MAX_READ_REGS)) begin                  // R10
            state_next.code = EXC_ILLEGAL_VALUE;
        end else if (analog && chk.reg_count > MAX_ANALOG_REGS) begin       // R11
            state_next.code = EXC_ILLEGAL_VALUE;
        end else if (is_write(chk.func_code) && !chk.wr_data_ok) begin      // R12
            state_next.code = EXC_ILLEGAL_VALUE;
        end else if (chk.func_code != FC_DEVICE_ID && (last_addr > ADDR_HI ||
                     (analog && last_addr > {1'b0, ANALOG_HI}))) begin      // R7
            state_next.code = EXC_ILLEGAL_ADDR;
        end else if (chk.func_code != FC_DEVICE_ID && !chk.point_present) begin  // R8
            state_next.code = EXC_ILLEGAL_ADDR;
        end else if (analog && !chk.point_analog) begin                     // R9
            state_next.code = EXC_ILLEGAL_ADDR;
        end else if (!chk.panel_online) begin                               // R14
            state_next.code = EXC_TARGET_FAILED;
        end else begin
            state_next.analog = analog;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign chk.done        = state_reg.done;
    assign chk.exc_code    = state_reg.code;
    assign chk.analog_read = state_reg.analog;

    a_done_follows: assert property (@(posedge clock) disable iff (!rst_n)
        chk.start |=> chk.done) else $error("checker verdict missing");
endmodule : mbxc_checker

/* File: mbxc_client.sv */
/* Client model: one request outstanding at a time.
   Assumes the gateway request ports and one shared clock. */
`timescale 1ns/10ps
module mbxc_client (
    input  wire logic        clock,        // Clock
    input  wire logic        req_ready,    // Gateway free
    input  wire logic        resp_valid,   // Response pulse
    output logic             req_valid,    // Request present
    output logic [15:0]      req_proto_id, // Protocol id
    output logic [7:0]       req_unit_id,  // Unit ID
    output logic [7:0]       req_func,     // Function code
    output logic [15:0]      req_addr,     // Start register
    output logic [15:0]      req_count,    // Register count
    output logic [15:0]      req_trans_id  // Transaction id
);
    initial req_valid = 1'b0;
    initial {req_proto_id, req_unit_id, req_func, req_addr, req_count, req_trans_id} = '0;
    // ==========================================================
    // Send one request and wait for its answer
    task send(input logic [79:0] r, output logic ok);
        int n;
        n = 0;
        @(negedge clock);
        while (req_ready !== 1'b1 && n < 8) begin
            @(negedge clock);
            n++;
        end
        {req_proto_id, req_unit_id, req_func, req_addr, req_count, req_trans_id} = r;
        req_valid = 1'b1;
        @(negedge clock);
        req_valid = 1'b0;
        {req_proto_id, req_unit_id, req_func, req_addr, req_count, req_trans_id} = ~r;
        n = 0;
        while (resp_valid !== 1'b1 && n < 8) begin
            @(negedge clock);
            n++;
        end
        ok = resp_valid;
    endtask : send
endmodule : mbxc_client

/* File: tb.sv */
/* Testbench of the request exception checker and its encoders.
   Assumes the client model drives the request side. */
`timescale 1ns/10ps
module tb;
    import mbxc_pkg::*;
    logic clock = 1'b0, rst_n = 1'b0, ok, point_absent = 1'b0;
    logic unit_cfg = 1'b1, panel_online = 1'b1, point_present = 1'b1;
    logic point_analog = 1'b1, wr_enable = 1'b1, wr_data_ok = 1'b1;
    logic [NUM_STATES-1:0] point_state = '0;
    logic [7:0] device_type = 8'h00, req_unit_id, req_func, resp_func, resp_code;
    logic [7:0] resp_unit_id, event_category;
    logic [15:0] req_trans_id, req_proto_id, req_addr, req_count, resp_trans_id, t = 16'h0000;
    logic req_valid, req_ready, resp_valid, resp_exc, resp_zero_fill, analog_poll_start;
    logic [1:0] device_class;
    logic [7:0] cat [12] = '{8'h10, 8'h11, 8'h12, 8'h13, 8'h20, 8'h21, 8'h30, 8'h40,
                             8'h52, 8'h55, 8'h71, 8'h72};
    logic [7:0] dt [8] = '{8'h00, 8'h01, 8'h32, 8'h33, 8'h96, 8'h97, 8'hfa, 8'hfb};
    int n_errors = 0, checked = 0;
    always #2 clock = ~clock;
    mbxc_client mbxc_client_i (.clock, .req_ready, .resp_valid, .req_valid, .req_proto_id,
        .req_unit_id, .req_func, .req_addr, .req_count, .req_trans_id);
    mbxc_gateway mbxc_gateway_i (.clock, .rst_n, .req_valid, .req_trans_id, .req_proto_id,
        .req_unit_id, .req_func, .req_addr, .req_count, .unit_cfg, .panel_online,
        .point_present, .point_analog, .wr_enable, .wr_data_ok, .point_state, .point_absent,
        .device_type, .req_ready, .resp_valid, .resp_exc, .resp_func, .resp_code,
        .resp_trans_id, .resp_unit_id, .resp_zero_fill, .analog_poll_start,
        .event_category, .device_class);
    // ==========================================================
    // Comparison, request and closing helpers
    task chk(input logic [23:0] g, e);
        checked++;
        if (g !== e) begin
            n_errors++;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    task req(input logic [5:0] s, input logic [15:0] p, a, c, input logic [7:0] f, x, z);
        {unit_cfg, panel_online, point_present, point_analog, wr_enable, wr_data_ok} = s;
        t = t + 16'h0001;
        mbxc_client_i.send({p, 8'h05, f, a, c, t}, ok);
        chk(ok, 1'b1);
        chk(req_ready, 1'b0);
        chk(resp_code, x);
        chk(resp_func, x != EXC_NONE ? f | FC_EXC_FLAG : f);
        chk(resp_exc, x != EXC_NONE);
        chk({resp_trans_id, resp_unit_id}, {t, 8'h05});
        chk({resp_zero_fill, analog_poll_start}, {2{z[0]}});
    endtask : req
    task close_out;
        if (n_errors == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : close_out
    // ==========================================================
    // Scenarios
    task t_exceptions;
        req(6'h1f, 16'h0001, 16'h0000, 16'h0001, 8'h03, 8'h01, 8'h00);
        req(6'h1f, 16'h0000, 16'h0000, 16'h0001, 8'h03, 8'h0a, 8'h00);
        req(6'h3d, 16'h0000, 16'h0000, 16'h0001, 8'h06, 8'h01, 8'h00);
        req(6'h3f, 16'h0000, 16'h0000, 16'h0001, 8'h07, 8'h01, 8'h00);
        req(6'h3f, 16'h0000, 16'h0000, 16'h0065, 8'h03, 8'h03, 8'h00);
        req(6'h3f, 16'h0000, 16'h0000, 16'h0064, 8'h03, 8'h00, 8'h00);
        req(6'h3e, 16'h0000, 16'h0000, 16'h0001, 8'h06, 8'h03, 8'h00);
        req(6'h3f, 16'h0000, 16'h89ff, 16'h0002, 8'h03, 8'h02, 8'h00);
        req(6'h37, 16'h0000, 16'h0000, 16'h0001, 8'h03, 8'h02, 8'h00);
        req(6'h37, 16'h0000, 16'h0000, 16'h0001, 8'h2b, 8'h00, 8'h00);
        req(6'h2f, 16'h0000, 16'h0000, 16'h0001, 8'h03, 8'h0b, 8'h00);
    endtask : t_exceptions
    task t_analog;
        req(6'h3f, 16'h0000, 16'h7530, 16'h000b, 8'h04, 8'h03, 8'h00);
        req(6'h3b, 16'h0000, 16'h7530, 16'h000a, 8'h04, 8'h02, 8'h00);
        req(6'h3f, 16'h0000, 16'h7530, 16'h000a, 8'h04, 8'h00, 8'h01);
        req(6'h3f, 16'h0000, 16'h7530, 16'h000a, 8'h04, 8'h00, 8'h00);
    endtask : t_analog
    task t_encoders;
        for (int i = 0; i < NUM_STATES; i++) begin
            point_state = 12'h800 | (12'h001 << i);
            device_type = dt[i % 8];
            @(negedge clock);
            chk(event_category, cat[i]);
            chk(device_class, 16'h3e94 >> (2 * (i % 8)) & 16'h0003);
        end
        point_state = '0;
        @(negedge clock);
        chk(event_category, CAT_NONE);
        point_absent = 1'b1;
        @(negedge clock);
        chk(event_category, CAT_NOT_PRESENT);
    endtask : t_encoders
    initial begin
        #4000;
        n_errors++;
        close_out();
    end
    initial begin
        repeat (12) @(posedge clock);
        @(negedge clock) rst_n = 1'b1;
        t_exceptions();
        t_analog();
        t_encoders();
        close_out();
    end
endmodule : tb
